// ===== logic/adc_port_pkg.sv
// constants for the converter ready flag and serial register port
// assumes core_clk is the 50 MHz master clock and the host drives sclk
`default_nettype none
package adc_port_pkg;
    // clocking and the blanking time ahead of a data update
    localparam int CORE_CLK_PERIOD_NS = 20;
    localparam int MASTER_CLOCK_PERIOD_NS = 20;
    localparam int BLANK_PERIODS = 500;
    localparam int BLANK_TIME_NS = BLANK_PERIODS * MASTER_CLOCK_PERIOD_NS;
    localparam int BLANK_CYCLES = (BLANK_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam logic [9:0] BLANK_LAST = 10'(BLANK_CYCLES - 1);

    // communications register layout
    localparam int RS_MSB = 6;
    localparam int RS_LSB = 4;
    localparam int RW_BIT = 3;
    localparam logic [2:0] RS_COMM = 3'h0;
    localparam logic [2:0] RS_SETUP = 3'h1;
    localparam logic [2:0] RS_CLOCK = 3'h2;
    localparam logic [2:0] RS_DATA = 3'h3;

    // reset values and read padding
    localparam logic [7:0] COMM_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h01;
    localparam logic [7:0] CLOCK_RESET = 8'h05;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] BYTE_PAD = 8'h00;

    // bit counter and blanking counter limits
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] LAST_BYTE_BIT = 4'h7;
    localparam logic [3:0] LAST_WORD_BIT = 4'hf;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;

    typedef enum logic [1:0] {PH_COMM, PH_WRITE, PH_READ} port_phase_t;
    typedef enum logic {UP_IDLE, UP_BLANK} update_state_t;
endpackage : adc_port_pkg
`default_nettype wire

// ===== logic/adc_ready_port.sv
// conversion-ready flag and serial register port of the converter
// assumes sample words and calibration done come from logic on core_clk
// and that the host owns sclk, cs_n and din.
// How it works
// [R1] conversion_ready_n goes low when a new result word sits in the data register.
// [R2] it goes high again once the host has shifted out a whole data word.
// [R3] if the old word was never read, it stays high 500 master clocks before the next update.
// [R4] the host must not read the data register while conversion_ready_n is high.
// [R5] once the data register is updated conversion_ready_n goes low again.
// [R6] a finished calibration also drives conversion_ready_n low when no sample arrives with it and no blanking runs.
// [R7] dout shifts out the comm, setup, clock or data register picked by the select field.
// [R8] din bits land in the setup, clock or comm register picked by the select field.
// [R9] cs_n low selects the port; held low it works as a three-wire port.
// [R10] the host supplies sclk, continuously or in bursts.
// [R11] rstn returns control, interface and filter-facing state to power-on values; the sclk-side registers reset only if sclk rises while rstn is low.
// [R12] din is sampled on rising sclk, dout changes on falling sclk, msb first.
`default_nettype none
module adc_ready_port
    import adc_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic [15:0] sample_data,
    input wire logic sample_valid,
    input wire logic cal_done,
    output logic dout,
    output logic conversion_ready_n,
    output logic [7:0] setup_cfg,
    output logic [7:0] clock_cfg
);
    // link side, clocked by sclk
    logic rst_s1;
    logic rst_s2;
    port_phase_t phase;
    port_phase_t next_phase;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] next_shift_in;
    logic [7:0] comm_reg;
    logic [7:0] next_comm_reg;
    logic [7:0] setup_reg;
    logic [7:0] next_setup_reg;
    logic [7:0] clock_reg;
    logic [7:0] next_clock_reg;
    logic [15:0] read_word;
    logic [15:0] next_read_word;
    logic read_tgl;
    logic next_read_tgl;
    logic cfg_tgl;
    logic next_cfg_tgl;
    logic next_dout;

    // core side
    logic [15:0] data_reg;
    logic [15:0] next_data_reg;
    logic [15:0] pending;
    logic [15:0] next_pending;
    logic [9:0] blank_cnt;
    logic [9:0] next_blank_cnt;
    update_state_t up_state;
    update_state_t next_up_state;
    logic next_ready_n;
    logic [7:0] next_setup_cfg;
    logic [7:0] next_clock_cfg;
    logic rd_s1;
    logic rd_s2;
    logic rd_s3;
    logic cf_s1;
    logic cf_s2;
    logic cf_s3;

    logic [15:0] word_in;
    logic [2:0] sel;
    logic [3:0] last_bit;
    logic read_edge;
    logic cfg_edge;

    // reset carried into sclk so the port restarts cleanly
    always_ff @(posedge sclk)
    begin
        rst_s1 <= rstn;
        rst_s2 <= rst_s1;
    end

    assign word_in = {shift_in[14:0], din};
    assign sel = comm_reg[RS_MSB:RS_LSB];
    // data is 16 bits wide, all other registers 8
    assign last_bit = (phase != PH_COMM && sel == RS_DATA) ? LAST_WORD_BIT : LAST_BYTE_BIT;

    always_comb
    begin
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_comm_reg = comm_reg;
        next_setup_reg = setup_reg;
        next_clock_reg = clock_reg;
        next_read_word = read_word;
        next_read_tgl = read_tgl;
        next_cfg_tgl = cfg_tgl;
        if (!rst_s2)
        begin
            next_phase = PH_COMM; // R11
            next_bit_cnt = BIT_FIRST;
            next_shift_in = DATA_RESET;
            next_comm_reg = COMM_RESET;
            next_setup_reg = SETUP_RESET;
            next_clock_reg = CLOCK_RESET;
            next_read_word = DATA_RESET;
            // toggles start level with the core-side sync flops, so no false edge
            next_read_tgl = 1'b0;
            next_cfg_tgl = 1'b0;
        end
        else if (cs_n)
        begin
            // deselect abandons any partial transfer
            next_phase = PH_COMM; // R9
            next_bit_cnt = BIT_FIRST;
        end
        else
        begin
            next_shift_in = word_in; // R12
            next_bit_cnt = bit_cnt + BIT_ONE;
            if (bit_cnt == last_bit)
            begin
                next_bit_cnt = BIT_FIRST;
                case (phase)
                    PH_COMM:
                    begin
                        next_comm_reg = word_in[7:0];
                        if (word_in[RW_BIT])
                        begin
                            next_phase = PH_READ;
                            case (word_in[RS_MSB:RS_LSB]) // R7
                                RS_COMM: next_read_word = {word_in[7:0], BYTE_PAD};
                                RS_SETUP: next_read_word = {setup_reg, BYTE_PAD};
                                RS_CLOCK: next_read_word = {clock_reg, BYTE_PAD};
                                RS_DATA: next_read_word = data_reg;
                                default: next_read_word = DATA_RESET;
                            endcase
                        end
                        else
                        begin
                            next_phase = PH_WRITE;
                        end
                    end
                    PH_WRITE:
                    begin
                        next_phase = PH_COMM;
                        case (sel) // R8
                            RS_COMM: next_comm_reg = word_in[7:0];
                            RS_SETUP: next_setup_reg = word_in[7:0];
                            RS_CLOCK: next_clock_reg = word_in[7:0];
                            default: next_comm_reg = comm_reg;
                        endcase
                        next_cfg_tgl = ~cfg_tgl;
                    end
                    PH_READ:
                    begin
                        next_phase = PH_COMM;
                        if (sel == RS_DATA)
                        begin
                            next_read_tgl = ~read_tgl; // R2
                        end
                    end
                    default: next_phase = PH_COMM;
                endcase
            end
        end
    end

    always_ff @(posedge sclk)
    begin
        phase <= next_phase;
        bit_cnt <= next_bit_cnt;
        shift_in <= next_shift_in;
        comm_reg <= next_comm_reg;
        setup_reg <= next_setup_reg;
        clock_reg <= next_clock_reg;
        read_word <= next_read_word;
        read_tgl <= next_read_tgl;
        cfg_tgl <= next_cfg_tgl;
    end

    // output bit picked from the counter, moved on the falling edge
    always_comb
    begin
        next_dout = dout;
        if (!rst_s2)
        begin
            next_dout = 1'b0;
        end
        else if (phase == PH_READ && !cs_n)
        begin
            next_dout = read_word[LAST_WORD_BIT - bit_cnt]; // R12
        end
    end

    always_ff @(negedge sclk)
    begin
        dout <= next_dout;
    end

    // toggles from the link, two flops then edge detect
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            rd_s3 <= 1'b0;
            cf_s1 <= 1'b0;
            cf_s2 <= 1'b0;
            cf_s3 <= 1'b0;
        end
        else if (ce)
        begin
            rd_s1 <= read_tgl;
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
            cf_s1 <= cfg_tgl;
            cf_s2 <= cf_s1;
            cf_s3 <= cf_s2;
        end
    end

    assign read_edge = rd_s2 ^ rd_s3;
    assign cfg_edge = cf_s2 ^ cf_s3;

    always_comb
    begin
        next_data_reg = data_reg;
        next_pending = pending;
        next_blank_cnt = blank_cnt;
        next_up_state = up_state;
        next_ready_n = conversion_ready_n;
        next_setup_cfg = setup_cfg;
        next_clock_cfg = clock_cfg;
        if (cfg_edge)
        begin
            // link registers sit still for many core cycles after a write
            next_setup_cfg = setup_reg;
            next_clock_cfg = clock_reg;
        end
        if (read_edge)
        begin
            next_ready_n = 1'b1; // R2
        end
        case (up_state)
            UP_IDLE:
            begin
                if (sample_valid)
                begin
                    if (!conversion_ready_n && !read_edge)
                    begin
                        next_pending = sample_data;
                        next_blank_cnt = BLANK_LAST; // R3
                        next_ready_n = 1'b1;
                        next_up_state = UP_BLANK;
                    end
                    else
                    begin
                        // word already consumed, no blanking needed
                        next_data_reg = sample_data;
                        next_ready_n = 1'b0; // R1
                    end
                end
                else if (cal_done)
                begin
                    next_ready_n = 1'b0; // R6
                end
            end
            UP_BLANK:
            begin
                next_ready_n = 1'b1; // R4
                if (sample_valid)
                begin
                    next_pending = sample_data;
                end
                if (blank_cnt == CNT_ZERO)
                begin
                    next_data_reg = sample_valid ? sample_data : pending;
                    next_ready_n = 1'b0; // R5
                    next_up_state = UP_IDLE;
                end
                else
                begin
                    next_blank_cnt = blank_cnt - CNT_ONE;
                end
            end
            default: next_up_state = UP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            data_reg <= DATA_RESET; // R11
            pending <= DATA_RESET;
            blank_cnt <= CNT_ZERO;
            up_state <= UP_IDLE;
            conversion_ready_n <= 1'b1;
            setup_cfg <= SETUP_RESET;
            clock_cfg <= CLOCK_RESET;
        end
        else if (ce)
        begin
            data_reg <= next_data_reg;
            pending <= next_pending;
            blank_cnt <= next_blank_cnt;
            up_state <= next_up_state;
            conversion_ready_n <= next_ready_n;
            setup_cfg <= next_setup_cfg;
            clock_cfg <= next_clock_cfg;
        end
    end
endmodule : adc_ready_port
`default_nettype wire

// ===== tb/adc_port_checker.sv
// checker for the ready flag, bound to the converter port top
// assumes core_clk clocks the flag logic and rstn is synchronous
`default_nettype none
module adc_port_checker
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sample_valid,
    input wire logic cal_done,
    input wire logic conversion_ready_n,
    input wire logic [7:0] setup_cfg,
    input wire logic [7:0] clock_cfg
);
    logic blank;
    logic [9:0] cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // mirrors the blanking window; cnt is the core cycle within it
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            blank <= 1'b0;
            cnt <= 10'h000;
        end
        else if (ce && sample_valid && !conversion_ready_n)
        begin
            blank <= 1'b1;
            cnt <= 10'h001;
        end
        else if (ce && blank)
        begin
            blank <= (cnt != 10'h1f5);
            cnt <= cnt + 10'h001;
        end
    end
    AST_RESET_VALUES: assert property (disable iff (1'b0) !rstn |=> conversion_ready_n
        && setup_cfg == 8'h01 && clock_cfg == 8'h05) else $error("reset values wrong");
    AST_LOAD: assert property (ce && sample_valid && conversion_ready_n && !blank
        |=> !conversion_ready_n) else $error("ready not low after load");
    AST_BLANK_START: assert property (ce && sample_valid && !conversion_ready_n
        |=> conversion_ready_n) else $error("no blanking on unread word");
    AST_BLANK_HOLD: assert property (blank && cnt <= 10'h1f4 |-> conversion_ready_n)
        else $error("ready low inside blanking");
    AST_BLANK_END: assert property (blank && cnt == 10'h1f5 |-> !conversion_ready_n)
        else $error("ready not low after blanking");
    AST_CAL: assert property (ce && cal_done && !sample_valid && !blank
        |=> !conversion_ready_n) else $error("calibration end not flagged");
    AST_CAL_REFUSED: assert property (blank && cal_done && cnt < 10'h1f4
        |=> conversion_ready_n) else $error("calibration cut blanking");
    AST_FALL_CAUSE: assert property ($fell(conversion_ready_n) |-> $past(sample_valid)
        || $past(cal_done) || $past(blank)) else $error("ready fell without cause");
endmodule : adc_port_checker
bind adc_ready_port adc_port_checker u_adc_port_checker (.core_clk(core_clk), .rstn(rstn),
    .ce(ce), .sample_valid(sample_valid), .cal_done(cal_done),
    .conversion_ready_n(conversion_ready_n), .setup_cfg(setup_cfg), .clock_cfg(clock_cfg));
`default_nettype wire

// ===== tb/host_model.sv
// host side of the serial port: frames, serial clock and bit shifting
// assumes the bench calls its tasks; sclk stands still between frames except when idle pulses it
`default_nettype none
module host_model
(
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // deselected pulses, so the port side sees its reset or drops a partial frame
    task automatic idle(input int n);
        repeat (n)
        begin
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
    endtask : idle
    // comm byte then n data bits; keep leaves the port selected
    task automatic access(input logic [7:0] comm, input logic [15:0] wr, input int n,
        input logic keep, output logic [15:0] rd);
        logic [23:0] tx;
        tx = {comm, 16'(wr << (16 - n))};
        rd = 16'h0000;
        cs_n = 1'b0;
        for (int i = 0; i < 8 + n; i++)
        begin
            din = tx[23 - i];
            #24;
            if (i >= 8) rd = {rd[14:0], dout};
            sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        if (!keep)
        begin
            // released line shows the inverse, never a stale level
            cs_n = 1'b1;
            din = ~din;
            #24;
        end
    endtask : access
endmodule : host_model
`default_nettype wire

// ===== tb/adc_ready_and_serial_port_test.sv
// bench for the ready flag and serial register port
// assumes host_model drives the serial side at a 48 ns bit period
`default_nettype none
module adc_ready_and_serial_port_test
    import adc_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, ce, sample_valid, cal_done, sclk, cs_n, din, dout;
    logic conversion_ready_n;
    logic [15:0] sample_data, rd;
    logic [7:0] setup_cfg, clock_cfg;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int s;
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            results();
        end
    end
    host_model u_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    adc_ready_port u_adc_ready_port (.core_clk(core_clk), .rstn(rstn), .ce(ce), .sclk(sclk),
        .cs_n(cs_n), .din(din), .sample_data(sample_data), .sample_valid(sample_valid),
        .cal_done(cal_done), .dout(dout), .conversion_ready_n(conversion_ready_n),
        .setup_cfg(setup_cfg), .clock_cfg(clock_cfg));
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check
    task automatic pulse(input logic [15:0] d, input logic cal);
        @(negedge core_clk);
        sample_data = d;
        sample_valid = !cal;
        cal_done = cal;
        @(negedge core_clk);
        sample_valid = 1'b0;
        cal_done = 1'b0;
    endtask : pulse
    // read completion crosses domains, so allow a few cycles
    task automatic wait_ready(input logic lvl);
        int k;
        k = 0;
        while (conversion_ready_n !== lvl && k < 20)
        begin
            @(negedge core_clk);
            k++;
        end
        check(conversion_ready_n === lvl, "ready level");
    endtask : wait_ready
    task automatic t_reset;
        check(conversion_ready_n === 1'b1, "ready after reset");
        check(setup_cfg === SETUP_RESET && clock_cfg === CLOCK_RESET, "cfg reset");
        u_host_model.access(8'h18, 16'h0000, 8, 1'b0, rd);
        check(rd === {BYTE_PAD, SETUP_RESET}, "setup readback");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_cfg;
        u_host_model.access(8'h10, 16'h00a5, 8, 1'b1, rd);
        u_host_model.access(8'h20, 16'h003c, 8, 1'b1, rd);
        u_host_model.access(8'h18, 16'h0000, 8, 1'b1, rd);
        check(rd === 16'h00a5, "three-wire readback");
        u_host_model.access(8'h08, 16'h0000, 8, 1'b1, rd);
        check(rd === 16'h0008, "comm readback");
        u_host_model.access(8'h48, 16'h00ff, 8, 1'b0, rd);
        check(rd === 16'h0000, "unused select");
        repeat (6) @(negedge core_clk);
        check(setup_cfg === 8'ha5 && clock_cfg === 8'h3c, "cfg copies");
        $display("t_cfg done");
    endtask : t_cfg
    // deselect only counts at a rising sclk, so one idle pulse cuts the frame
    task automatic t_abort;
        u_host_model.access(8'h10, 16'h0005, 4, 1'b0, rd);
        u_host_model.idle(1);
        u_host_model.access(8'h30, 16'hffff, 16, 1'b0, rd);
        u_host_model.access(8'h18, 16'h0000, 8, 1'b0, rd);
        check(rd === 16'h00a5, "setup kept after abort");
        $display("t_abort done");
    endtask : t_abort
    task automatic t_data;
        @(negedge core_clk);
        ce = 1'b0;
        pulse(16'h0bad, 1'b0);
        check(conversion_ready_n === 1'b1, "frozen while ce low");
        ce = 1'b1;
        pulse(16'h1234, 1'b0);
        wait_ready(1'b0);
        u_host_model.access(8'h38, 16'h0000, 16, 1'b0, rd);
        check(rd === 16'h1234, "data word");
        wait_ready(1'b1);
        pulse(16'h0000, 1'b1);
        check(conversion_ready_n === 1'b0, "calibration flag");
        $display("t_data done");
    endtask : t_data
    task automatic t_blank;
        pulse(16'hc0de, 1'b0);
        s = cycles;
        check(conversion_ready_n === 1'b1, "blanking started");
        pulse(16'hcafe, 1'b0);
        pulse(16'h0000, 1'b1);
        while (conversion_ready_n === 1'b1 && cycles - s < 600) @(negedge core_clk);
        check(cycles - s == BLANK_PERIODS, "blanking length");
        u_host_model.access(8'h38, 16'h0000, 16, 1'b0, rd);
        check(rd === 16'hcafe, "newest word");
        wait_ready(1'b1);
        $display("t_blank done");
    endtask : t_blank
    task automatic results;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        sample_valid = 1'b0;
        cal_done = 1'b0;
        sample_data = 16'h0000;
        fork
            u_host_model.idle(4);
            repeat (20) @(negedge core_clk);
        join
        rstn = 1'b1;
        u_host_model.idle(3);
        t_reset();
        t_cfg();
        t_abort();
        t_data();
        t_blank();
        results();
    end
endmodule : adc_ready_and_serial_port_test
`default_nettype wire
